// ===== rtl/paws_access_timer.sv
/*
  Wait-state timer for processor accesses to the quad serial, flash, serial
  and SPI register windows. Takes one request at a time, counts the access in
  unit-clock ticks and answers with a one-cycle done pulse.
  Assumes unit-clock ticks arrive as core-clock pulses, and that the quad
  serial controller reports the end of its bus cycles as a pulse.
*/
`timescale 1ns/1ps
// Overview of operation
// - Low quad serial window: read 5, faster core 2 to 5; write at least 14.
// - Quad serial transfer word: read at least 25; write at least 6, or 5 if faster.
// - Quad serial window 0x14 to 0x37 uses the low window timing.
// - Quad serial word at 0x804: read 4, write 3; faster core 1 to 4, 1 to 3.
// - Data flash and command window: 3 flash cycles, faster core 2 to 3.
// - Fractional counts truncate the lower bound and round up the upper.
// - 16-bit serial data, FIFO, status and compare accesses add 2 cycles.
// - 8-bit serial data byte accesses add nothing.
// - 32-bit SPI data accesses add 2; 8 or 16-bit alias accesses add nothing.
// - Open-ended quad serial accesses end only when its bus cycles end.
module paws_access_timer
  import paws_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_req,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_write,
  input wire logic [1:0] i_size,
  input wire logic i_peripheral_clock_a_tick,
  input wire logic i_flash_interface_clock_tick,
  input wire logic i_peripheral_clock_a_eq_core,
  input wire logic i_flash_interface_clock_eq_core,
  input wire logic i_qspi_cycle_done,
  output logic o_busy,
  output logic o_done,
  output logic o_err,
  output logic o_start,
  output logic [2:0] o_window
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ----------------------------------------
  // Decode and count lookup
  // ----------------------------------------
  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  function automatic paws_win_t win_decode(input logic [31:0] a);
    if (in_range(a, QSPI_LOW_FROM, QSPI_LOW_TO) || in_range(a, QSPI_HIGH_FROM, QSPI_HIGH_TO))
    begin
      win_decode = WIN_QSPI_CTRL;
    end
    else if (in_range(a, QSPI_XFER_FROM, QSPI_XFER_TO))
    begin
      win_decode = WIN_QSPI_XFER;
    end
    else if (in_range(a, QSPI_DIRECT_FROM, QSPI_DIRECT_TO))
    begin
      win_decode = WIN_QSPI_DIRECT;
    end
    else if (in_range(a, FLASH_FROM, FLASH_TO))
    begin
      win_decode = WIN_FLASH;
    end
    else if (in_range(a, SERIAL_FROM, SERIAL_TO))
    begin
      win_decode = WIN_SERIAL;
    end
    else if (in_range(a, SPI_FROM, SPI_TO))
    begin
      win_decode = WIN_SPI;
    end
    else
    begin
      win_decode = WIN_NONE;
    end
  endfunction : win_decode

  // Fast-core figures are whole numbers already truncated to the lower bound
  function automatic logic [7:0] base_count(input paws_win_t w, input logic wr, input logic eq);
    unique case (w)
      WIN_QSPI_CTRL: base_count = wr ? QSPI_CTRL_WR : (eq ? QSPI_CTRL_RD_EQ : QSPI_CTRL_RD_FAST);
      WIN_QSPI_XFER: base_count = wr ? (eq ? QSPI_XFER_WR_EQ : QSPI_XFER_WR_FAST) : QSPI_XFER_RD;
      WIN_QSPI_DIRECT: base_count = eq ? (wr ? QSPI_DIRECT_WR_EQ : QSPI_DIRECT_RD_EQ) : QSPI_DIRECT_FAST;
      WIN_FLASH: base_count = eq ? FLASH_EQ : FLASH_FAST;
      WIN_SERIAL, WIN_SPI: base_count = eq ? (wr ? PERIPH_WR_EQ : PERIPH_RD_EQ) : PERIPH_FAST;
      default: base_count = CNT_RESET;
    endcase
  endfunction : base_count

  function automatic logic [7:0] wide_extra(input paws_win_t w, input logic [1:0] sz);
    if ((w == WIN_SERIAL) && (sz == SIZE_16))
    begin
      wide_extra = WIDE_EXTRA;
    end
    else if ((w == WIN_SPI) && (sz == SIZE_32))
    begin
      wide_extra = WIDE_EXTRA;
    end
    else
    begin
      wide_extra = CNT_RESET;
    end
  endfunction : wide_extra

  // Windows whose end depends on quad serial bus activity
  function automatic logic open_ended(input paws_win_t w, input logic wr);
    open_ended = ((w == WIN_QSPI_CTRL) && wr) || (w == WIN_QSPI_XFER);
  endfunction : open_ended

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'h0,
    ST_COUNT = 2'h1,
    ST_BUSWAIT = 2'h3,
    ST_DONE = 2'h2
  } paws_state_t;

  paws_state_t state_r;
  paws_state_t state_nxt;
  paws_win_t req_win;
  paws_win_t win_r;
  logic open_r;
  logic seen_r;
  logic seen_now;
  logic accept;
  logic load_ok;
  logic unit_eq;
  logic unit_tick;
  logic cnt_last;
  logic [7:0] load_val;

  assign req_win = win_decode(i_addr);
  assign accept = (state_r == ST_IDLE) && i_req;
  assign load_ok = accept && (req_win != WIN_NONE);
  assign unit_eq = (req_win == WIN_FLASH) ? i_flash_interface_clock_eq_core : i_peripheral_clock_a_eq_core;
  assign load_val = base_count(req_win, i_write, unit_eq) + wide_extra(req_win, i_size);
  // Flash window counts flash clock; all others peripheral clock A
  assign unit_tick = (win_r == WIN_FLASH) ? i_flash_interface_clock_tick : i_peripheral_clock_a_tick;
  // Bus end reported in the same cycle as the last tick still counts
  assign seen_now = seen_r || i_qspi_cycle_done;

  paws_wait_counter #(
    .W(CNT_W)
  ) u_wait_counter (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_sync_r),
    .i_clk_en(i_clk_en),
    .i_load(load_ok),
    .i_load_val(load_val),
    .i_tick(unit_tick && (state_r == ST_COUNT)),
    .o_last(cnt_last)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
      begin
        if (accept)
        begin
          state_nxt = (req_win == WIN_NONE) ? ST_DONE : ST_COUNT;
        end
      end
      ST_COUNT:
      begin
        if (cnt_last)
        begin
          state_nxt = (open_r && !seen_now) ? ST_BUSWAIT : ST_DONE;
        end
      end
      ST_BUSWAIT:
      begin
        if (i_qspi_cycle_done)
        begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      state_r <= ST_IDLE;
    end
    else if (i_clk_en)
    begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // Captured request
  // ----------------------------------------
  // Held internally so a master that drops its address early cannot
  // retime the access in flight
  always_ff @(posedge i_clk_sys or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      win_r <= WIN_NONE;
      open_r <= 1'b0;
    end
    else if (i_clk_en && accept)
    begin
      win_r <= req_win;
      open_r <= open_ended(req_win, i_write);
    end
  end

  // Bus end flag; a report in the accept cycle wins over the clear
  always_ff @(posedge i_clk_sys or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      seen_r <= 1'b0;
    end
    else if (i_clk_en)
    begin
      seen_r <= i_qspi_cycle_done || (seen_r && !accept);
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Taken from the next state so both leave a flip-flop
  always_ff @(posedge i_clk_sys or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_busy <= (state_nxt != ST_IDLE) && (state_nxt != ST_DONE);
      o_done <= (state_nxt == ST_DONE);
    end
  end

  // Accept reports: error for an unmapped address, start for a mapped one
  always_ff @(posedge i_clk_sys or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      o_err <= 1'b0;
      o_start <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_err <= accept && (req_win == WIN_NONE);
      o_start <= load_ok;
    end
  end

  // Window code stands until the next accept
  always_ff @(posedge i_clk_sys or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      o_window <= WIN_NONE;
    end
    else if (i_clk_en && accept)
    begin
      o_window <= req_win;
    end
  end

endmodule : paws_access_timer

// ===== rtl/paws_pkg.sv
/*
  Constants for the peripheral access wait-state block: address windows,
  access counts in peripheral or flash clock cycles, the extra cycles for wide
  serial and SPI data accesses, and the access-size encoding.
  Assumes a 32-bit byte address from the system bus and integer cycle counts.
*/
package paws_pkg;

  // ----------------------------------------
  // Widths and encodings
  // ----------------------------------------
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned CNT_W = 8;

  typedef enum logic [2:0]
  {
    WIN_NONE = 3'h0,
    WIN_QSPI_CTRL = 3'h1,
    WIN_QSPI_XFER = 3'h2,
    WIN_QSPI_DIRECT = 3'h3,
    WIN_FLASH = 3'h4,
    WIN_SERIAL = 3'h5,
    WIN_SPI = 3'h6
  } paws_win_t;

  typedef enum logic [1:0]
  {
    SIZE_8 = 2'h0,
    SIZE_16 = 2'h1,
    SIZE_32 = 2'h2
  } paws_size_t;

  // ----------------------------------------
  // Address windows (inclusive bounds)
  // ----------------------------------------
  localparam logic [31:0] QSPI_LOW_FROM = 32'h6400_0000;
  localparam logic [31:0] QSPI_LOW_TO = 32'h6400_000F;
  localparam logic [31:0] QSPI_XFER_FROM = 32'h6400_0010;
  localparam logic [31:0] QSPI_XFER_TO = 32'h6400_0013;
  localparam logic [31:0] QSPI_HIGH_FROM = 32'h6400_0014;
  localparam logic [31:0] QSPI_HIGH_TO = 32'h6400_0037;
  localparam logic [31:0] QSPI_DIRECT_FROM = 32'h6400_0804;
  localparam logic [31:0] QSPI_DIRECT_TO = 32'h6400_0807;
  localparam logic [31:0] FLASH_FROM = 32'h407F_C000;
  localparam logic [31:0] FLASH_TO = 32'h407F_EFFF;
  localparam logic [31:0] SERIAL_FROM = 32'h4011_8000;
  localparam logic [31:0] SERIAL_TO = 32'h4011_8FFF;
  localparam logic [31:0] SPI_FROM = 32'h4011_A000;
  localparam logic [31:0] SPI_TO = 32'h4011_AFFF;

  // ----------------------------------------
  // Access counts: EQ = core clock equals unit clock, FAST = core faster
  // Fast figures are the lower bound of each printed range
  // ----------------------------------------
  localparam logic [7:0] QSPI_CTRL_RD_EQ = 8'h05;
  localparam logic [7:0] QSPI_CTRL_RD_FAST = 8'h02;
  localparam logic [7:0] QSPI_CTRL_WR = 8'h0E;
  localparam logic [7:0] QSPI_XFER_RD = 8'h19;
  localparam logic [7:0] QSPI_XFER_WR_EQ = 8'h06;
  localparam logic [7:0] QSPI_XFER_WR_FAST = 8'h05;
  localparam logic [7:0] QSPI_DIRECT_RD_EQ = 8'h04;
  localparam logic [7:0] QSPI_DIRECT_WR_EQ = 8'h03;
  localparam logic [7:0] QSPI_DIRECT_FAST = 8'h01;
  localparam logic [7:0] FLASH_EQ = 8'h03;
  localparam logic [7:0] FLASH_FAST = 8'h02;
  localparam logic [7:0] PERIPH_RD_EQ = 8'h05;
  localparam logic [7:0] PERIPH_WR_EQ = 8'h04;
  localparam logic [7:0] PERIPH_FAST = 8'h02;
  localparam logic [7:0] WIDE_EXTRA = 8'h02;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] CNT_RESET = 8'h00;

endpackage : paws_pkg

// ===== rtl/paws_wait_counter.sv
/*
  Down counter of unit-clock ticks for one access.
  Assumes tick is a one-cycle pulse on the core clock per unit-clock cycle
  and that a load value is never zero.
*/
`timescale 1ns/1ps
module paws_wait_counter
  import paws_pkg::*;
#(
  parameter int unsigned W = CNT_W
)
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_load,
  input wire logic [W-1:0] i_load_val,
  input wire logic i_tick,
  output logic o_last
);

  logic [W-1:0] cnt_r;

  // ----------------------------------------
  // Count
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_r <= W'(CNT_RESET);
    end
    else if (i_clk_en)
    begin
      if (i_load)
      begin
        cnt_r <= i_load_val;
      end
      else if (i_tick && (cnt_r != '0))
      begin
        cnt_r <= cnt_r - W'(1);
      end
    end
  end

  // Last tick of the count; zero never fires again
  assign o_last = i_tick && (cnt_r == W'(1));

endmodule : paws_wait_counter

// ===== verif/paws_access_timer_sva.sv
/*
  Checker for the access timer: fixed latencies per window and open-ended waits.
  Assumes unit ticks held high, so each core cycle is one unit cycle.
*/
`timescale 1ns/1ps
module paws_access_timer_chk
  import paws_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_req,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_write,
  input wire logic [1:0] i_size,
  input wire logic i_peripheral_clock_a_eq_core,
  input wire logic i_flash_interface_clock_eq_core,
  input wire logic i_qspi_cycle_done,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_err,
  input wire logic o_start,
  input wire logic [2:0] o_window
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  logic [1:0] rdy_r;
  logic [7:0] cnt_r;
  logic [7:0] min_r;
  logic open_r;
  logic qd_r;
  logic acc;
  logic [2:0] w;
  logic eq_a;
  logic eq_f;
  function automatic logic [2:0] win_of(input logic [31:0] a);
    if ((a >= QSPI_LOW_FROM && a <= QSPI_LOW_TO) || (a >= QSPI_HIGH_FROM && a <= QSPI_HIGH_TO))
      return 3'h1;
    if (a >= QSPI_XFER_FROM && a <= QSPI_XFER_TO)
      return 3'h2;
    if (a >= QSPI_DIRECT_FROM && a <= QSPI_DIRECT_TO)
      return 3'h3;
    if (a >= FLASH_FROM && a <= FLASH_TO)
      return 3'h4;
    if (a >= SERIAL_FROM && a <= SERIAL_TO)
      return 3'h5;
    if (a >= SPI_FROM && a <= SPI_TO)
      return 3'h6;
    return 3'h0;
  endfunction : win_of
  assign w = win_of(i_addr);
  assign eq_a = i_peripheral_clock_a_eq_core;
  assign eq_f = i_flash_interface_clock_eq_core;
  // Reset leaves through two flops, so third edge is the first accept
  assign acc = rdy_r[1] && i_clk_en && i_req && !o_busy && !o_done;
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rdy_r <= 2'h0;
    else
      rdy_r <= {rdy_r[0], 1'b1};
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_r <= 8'h00;
      open_r <= 1'b0;
      min_r <= 8'h00;
      qd_r <= 1'b0;
    end
    else if (acc)
    begin
      cnt_r <= 8'h01;
      open_r <= (w == 3'h2) || (w == 3'h1 && i_write);
      min_r <= (w == 3'h2) ? (i_write ? (eq_a ? 8'h06 : 8'h05) : 8'h19) : 8'h0E;
      qd_r <= i_qspi_cycle_done;
    end
    else
    begin
      cnt_r <= (cnt_r == 8'hFF) ? cnt_r : cnt_r + 8'h01;
      qd_r <= qd_r | i_qspi_cycle_done;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  ctrl_read_a: assert property (acc && w == 3'h1 && !i_write && eq_a |=> !o_done[*5] ##1 o_done)
    else $error("ctrl read latency");
  direct_read_a: assert property (acc && w == 3'h3 && !i_write && eq_a |=> o_busy[*4] ##1 o_done)
    else $error("direct read latency");
  direct_fast_a: assert property (acc && w == 3'h3 && i_write && !eq_a |-> ##2 o_done)
    else $error("direct fast write latency");
  flash_eq_a: assert property (acc && w == 3'h4 && eq_f |-> ##4 o_done)
    else $error("flash latency");
  flash_fast_a: assert property (acc && w == 3'h4 && !eq_f |=> !o_done ##1 !o_done ##1 o_done)
    else $error("flash fast latency");
  serial_wide_a: assert property (acc && w == 3'h5 && i_size == 2'h1 && eq_a && !i_write
    |=> !o_done[*7] ##1 o_done)
    else $error("serial halfword latency");
  serial_byte_a: assert property (acc && w == 3'h5 && i_size == 2'h0 && !eq_a |-> ##3 o_done)
    else $error("serial byte latency");
  spi_wide_a: assert property (acc && w == 3'h6 && i_size == 2'h2 && i_write && eq_a |-> ##7 o_done)
    else $error("spi word latency");
  start_pulse_a: assert property (acc && w != 3'h0 |=> o_start && o_busy && !o_err)
    else $error("start pulse missing");
  unmapped_err_a: assert property (acc && w == 3'h0 |=> o_err && o_done && !o_start && !o_busy)
    else $error("unmapped access report");
  done_pulse_a: assert property (o_done && i_clk_en |=> !o_done && !o_busy)
    else $error("done longer than one cycle");
  freeze_hold_a: assert property (!i_clk_en |=> $stable(o_busy) && $stable(o_done) && $stable(o_window))
    else $error("state moved while enable low");
  open_min_a: assert property (o_done && open_r |-> qd_r && cnt_r > min_r)
    else $error("open access ended early");
  window_code_a: assert property (acc |=> o_window == $past(w))
    else $error("window code");
  cover property (acc && w == 3'h2);
  cover property (acc && w == 3'h0);
  cover property (o_done && open_r && cnt_r > 8'h1E);
  cover property (acc && !eq_a);
endmodule : paws_access_timer_chk

bind paws_access_timer paws_access_timer_chk u_chk (.i_clk_sys, .i_rst_n, .i_clk_en, .i_req, .i_addr, .i_write,
  .i_size, .i_peripheral_clock_a_eq_core, .i_flash_interface_clock_eq_core, .i_qspi_cycle_done, .o_busy, .o_done,
  .o_err, .o_start, .o_window);

// ===== verif/paws_cpu_model.sv
/*
  Processor bus master model: one access at a time, returns latency and error.
  Assumes the timer answers every accepted request with a done pulse.
*/
`timescale 1ns/1ps
module paws_cpu_model
(
  input wire logic i_clk_sys,
  input wire logic i_done,
  input wire logic i_err,
  output logic o_req,
  output logic [31:0] o_addr,
  output logic o_write,
  output logic [1:0] o_size
);
  initial
  begin
    o_req = 1'b0;
    o_addr = 32'h0000_0000;
    o_write = 1'b0;
    o_size = 2'h0;
  end
  // Latency is the done cycle minus one, counted from the request cycle
  task automatic access(input logic [31:0] a, input logic w, input logic [1:0] s, output int lat, output logic e);
    int n;
    @(posedge i_clk_sys);
    o_req <= 1'b1;
    o_addr <= a;
    o_write <= w;
    o_size <= s;
    n = 0;
    do
    begin
      @(posedge i_clk_sys);
      n++;
    end
    while (i_done !== 1'b1 && n < 300);
    lat = n - 2;
    e = i_err;
    o_req <= 1'b0;
    // Released bus shows no stale address
    o_addr <= ~a;
    o_write <= ~w;
    o_size <= ~s;
  endtask : access
endmodule : paws_cpu_model

// ===== verif/tb_top.sv
/*
  Self-checking bench for the access timer: window corners, then random accesses.
  Assumes ticks held high and the quad serial end pulse driven here.
*/
`timescale 1ns/1ps
module tb_top;
  logic clk_sys, rst_n, clk_en, ptick, ftick, eqp, eqf, qd, req, write, busy, done, err, start;
  logic [31:0] addr;
  logic [1:0] size;
  logic [2:0] win;
  int mismatches = 0;
  int n_tests = 0;
  logic [31:0] base [8] = '{32'h6400_0000, 32'h6400_0014, 32'h6400_0010, 32'h6400_0804, 32'h407F_C000,
    32'h4011_8000, 32'h4011_A000, 32'h6400_0038};
  int span [8] = '{32'h0F, 32'h23, 32'h3, 32'h3, 32'h2FFF, 32'hFFF, 32'hFFF, 32'h7CB};
  logic [2:0] wc [8] = '{3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0};
  paws_access_timer u_paws_access_timer (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_clk_en(clk_en), .i_req(req),
    .i_addr(addr), .i_write(write), .i_size(size), .i_peripheral_clock_a_tick(ptick),
    .i_flash_interface_clock_tick(ftick), .i_peripheral_clock_a_eq_core(eqp), .i_flash_interface_clock_eq_core(eqf),
    .i_qspi_cycle_done(qd), .o_busy(busy), .o_done(done),
    .o_err(err), .o_start(start), .o_window(win));
  paws_cpu_model u_paws_cpu_model (.i_clk_sys(clk_sys), .i_done(done), .i_err(err), .o_req(req),
    .o_addr(addr), .o_write(write), .o_size(size));
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  function automatic int exp_n(input logic [2:0] w, input logic wr, input logic [1:0] s, input logic ep,
    input logic ef, input int k);
    int n;
    case (w)
      3'h1: n = wr ? 14 : (ep ? 5 : 2);
      3'h2: n = wr ? (ep ? 6 : 5) : 25;
      3'h3: n = ep ? (wr ? 3 : 4) : 1;
      3'h4: n = ef ? 3 : 2;
      3'h5, 3'h6: n = (ep ? (wr ? 4 : 5) : 2) + (((w == 3'h5 && s == 2'h1) || (w == 3'h6 && s == 2'h2)) ? 2 : 0);
      default: n = 0;
    endcase
    // Open-ended accesses wait for the quad serial bus
    if ((w == 3'h1 && wr) || w == 3'h2)
      n = (k > n) ? k : n;
    return n;
  endfunction : exp_n
  task automatic chk_lat(input int got, input int exp);
    n_tests++;
    if (got != exp)
    begin
      mismatches++;
      $display("wrong value at %0t: latency %0d not %0d", $time, got, exp);
    end
  endtask : chk_lat
  task automatic chk_flags(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: err/window %h not %h", $time, got, exp);
    end
  endtask : chk_flags
  task automatic run(input int i, input int off, input int d);
    logic w, ep, ef, e;
    logic [1:0] s;
    int k, lat, n;
    w = $urandom % 2;
    s = $urandom % 3;
    ep = $urandom % 2;
    ef = $urandom % 2;
    k = 1 + $urandom % 40;
    n = exp_n(wc[i], w, s, ep, ef, k) + d;
    @(posedge clk_sys);
    eqp <= ep;
    eqf <= ef;
    // Enable low first: the pending request is taken d edges late
    clk_en <= (d == 0);
    fork
      u_paws_cpu_model.access(base[i] + off, w, s, lat, e);
      if ((wc[i] == 3'h1 && w) || wc[i] == 3'h2)
      begin
        repeat (k + 1 + d) @(posedge clk_sys);
        qd <= 1'b1;
        @(posedge clk_sys);
        qd <= 1'b0;
      end
      if (d > 0)
      begin
        repeat (d + 1) @(posedge clk_sys);
        clk_en <= 1'b1;
      end
    join
    chk_lat(lat, n);
    chk_flags({e, win}, {wc[i] == 3'h0, wc[i]});
  endtask : run
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  initial
  begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    ptick = 1'b1;
    ftick = 1'b1;
    eqp = 1'b1;
    eqf = 1'b1;
    qd = 1'b0;
    void'($urandom(32'h8E83684B));
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // Window edges catch off-by-one bounds
    for (int i = 0; i < 8; i++)
    begin
      run(i, 0, 0);
      run(i, span[i], 3);
    end
    $display("test window corners done");
    repeat (150)
    begin
      int i;
      i = $urandom % 8;
      run(i, $urandom % (span[i] + 1), $urandom % 3);
    end
    $display("test random accesses done");
    final_report();
  end
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    mismatches++;
    final_report();
  end
endmodule : tb_top
